/* File: hdl/arp_defs.svh */
/*
  Named constants of the record path: widths, register addresses, field positions and counts.
  Assumes it is included by the package and by every design file that needs a number.
*/
`ifndef ARP_DEFS_SVH
`define ARP_DEFS_SVH
`define ARP_THERM_W 31
`define ARP_SINC_W 26
`define ARP_WORD_W 24
`define ARP_GAIN_W 6
`define ARP_GAIN_MAX 6'h30
`define ARP_THERM_MID 6'h10
`define ARP_SINC_LAST_LONG 4'hF
`define ARP_SINC_LAST_SHORT 4'h7
`define ARP_SHORT_SHIFT 5
`define ARP_HB_SHIFT 5
`define ARP_HB_STAGES 3
`define ARP_VOL_FULL 9'h100
`define ARP_VOL_MSB 31
`define ARP_VOL_LSB 8
`define ARP_LEVEL_MSB 22
`define ARP_LEVEL_LSB 15
`define ARP_ADDR_ADC_CTRL 7'h6F
`define ARP_ADDR_GAIN_L 7'h70
`define ARP_ADDR_GAIN_R 7'h71
`define ARP_ADDR_VOL_L 7'h72
`define ARP_ADDR_VOL_R 7'h73
`define ARP_ADDR_PEAK_L 7'h74
`define ARP_ADDR_PEAK_R 7'h75
`define ARP_ADDR_CLK_CTRL 7'h76
`define ARP_ADDR_ALC1 7'h78
`define ARP_ADDR_ALC2 7'h79
`define ARP_ADDR_ALC3 7'h7A
`define ARP_ADDR_ALC4 7'h7B
`define ARP_ADDR_ALC_STAT 7'h7C
`define ARP_ADC_QUARTER_BIT 0
`define ARP_ROUTE_PORT_BIT 1
`define ARP_ROUTE_SRC_BIT 2
`define ARP_ROUTE_SPDIF_BIT 3
`define ARP_ALC_EN_BIT 0
`define ARP_ALC_BOTH_BIT 1
`define ARP_ALC_MODE_LSB 2
`define ARP_ALC_MODE_MSB 3
`define ARP_EXC_MAX_LSB 4
`define ARP_EXC_MAX_MSB 7
`define ARP_ATK_TIME_MSB 3
`define ARP_REC_TIME_LSB 4
`define ARP_ATK_FILL 4'hF
`define ARP_REC_FILL 8'hFF
`define ARP_SPI_HEAD_BITS 5'h08
`define ARP_SPI_FRAME_BITS 5'h10
`endif

/* File: hdl/arp_pkg.sv */
/*
  Types of the record path: level control states, recovery modes and the state records.
  Assumes arp_defs.svh is on the include path.
*/
`include "arp_defs.svh"
package arp_pkg;
  typedef enum logic [1:0] {
    ARP_ALC_OFF = 2'b00,
    ARP_ALC_WATCH = 2'b01,
    ARP_ALC_ATTACK = 2'b10
  } arp_alc_state_t;

  typedef enum logic [1:0] {
    ARP_REC_NONE = 2'b00,
    ARP_REC_NORMAL = 2'b01,
    ARP_REC_LIMITED = 2'b10
  } arp_rec_mode_t;

  typedef struct packed {
    logic [4:0][`ARP_SINC_W-1:0] integ;
    logic [4:0][`ARP_SINC_W-1:0] combDly;
    logic [3:0] sincCnt;
    logic [`ARP_HB_STAGES-1:0][6:0][`ARP_SINC_W-1:0] hbTap;
    logic [`ARP_HB_STAGES-1:0] hbPh;
    logic [`ARP_WORD_W-1:0] word;
    logic wordVld;
    logic [7:0] level;
    logic [7:0] peak;
  } arp_chan_state_t;

  typedef struct packed {
    logic [2:0] pinSync1;
    logic [2:0] pinSync2;
    logic clkPrev;
    logic [15:0] shiftIn;
    logic [4:0] bitCnt;
    logic [7:0] shiftOut;
    logic dataOut;
    logic [`ARP_THERM_W-1:0] thermL1;
    logic [`ARP_THERM_W-1:0] thermL2;
    logic [`ARP_THERM_W-1:0] thermR1;
    logic [`ARP_THERM_W-1:0] thermR2;
    logic [7:0] clkCtrl;
    logic [7:0] adcCtrl;
    logic [7:0] gainInitL;
    logic [7:0] gainInitR;
    logic [7:0] volL;
    logic [7:0] volR;
    logic [7:0] alc1;
    logic [7:0] alc2;
    logic [7:0] alc3;
    logic [7:0] alc4;
    logic [1:0] mclkCnt;
    logic [1:0] modCnt;
    logic modStb;
    logic modClk;
    logic peakClrL;
    logic peakClrR;
    arp_alc_state_t alcState;
    logic [`ARP_GAIN_W-1:0] gainOff;
    logic [11:0] alcTimer;
    logic [3:0] excCnt;
    logic recSeen;
    logic alcEnPrev;
    logic alcRst;
    logic [`ARP_GAIN_W-1:0] gainL;
    logic [`ARP_GAIN_W-1:0] gainR;
    logic [`ARP_WORD_W-1:0] sampleL;
    logic [`ARP_WORD_W-1:0] sampleR;
    logic portVld;
    logic srcVld;
    logic spdifVld;
  } arp_top_state_t;
endpackage : arp_pkg

/* File: hdl/arp_chan_if.sv */
/*
  Link between the record path top and one channel of the decimation chain.
  Assumes both ends run on core_clk; every strobe is one cycle wide.
*/
`timescale 1ns/1ps
`include "arp_defs.svh"
interface arp_chan_if;
  logic [`ARP_THERM_W-1:0] therm;
  logic modStb;
  logic sincShort;
  logic [7:0] volume;
  logic peakClr;
  logic [`ARP_WORD_W-1:0] word;
  logic wordVld;
  logic [7:0] level;
  logic [7:0] peak;
  modport top (output therm, modStb, sincShort, volume, peakClr, input word, wordVld, level, peak);
  modport chan (input therm, modStb, sincShort, volume, peakClr, output word, wordVld, level, peak);
endinterface : arp_chan_if

/* File: hdl/arp_chan.sv */
/*
  One record channel: thermometer decode, sinc5 decimator, three half-band stages,
  volume scaling and peak hold.
  Assumes modStb marks each modulator sample and therm is already synchronised.
*/
`timescale 1ns/1ps
`include "arp_defs.svh"
module arp_chan (
  input wire logic core_clk,
  input wire logic resetn,
  arp_chan_if.chan ch
);
  arp_pkg::arp_chan_state_t s_q;
  arp_pkg::arp_chan_state_t s_d;

  function automatic logic [5:0] countOnes(input logic [`ARP_THERM_W-1:0] t);
    logic [5:0] c;
    c = '0;
    for (int i = 0; i < `ARP_THERM_W; i++) begin
      c = c + {5'h00, t[i]};
    end
    return c;
  endfunction : countOnes

  function automatic logic signed [31:0] ext(input logic [`ARP_SINC_W-1:0] v);
    return $signed({{(32-`ARP_SINC_W){v[`ARP_SINC_W-1]}}, v});
  endfunction : ext

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [5:0] dIn;
    logic [`ARP_SINC_W-1:0] x;
    logic [`ARP_SINC_W-1:0] y;
    logic push;
    logic signed [31:0] acc;
    logic [`ARP_WORD_W-1:0] w;
    logic [`ARP_WORD_W-1:0] mag;
    logic signed [33:0] prod;
    logic [7:0] lvl;
    dIn = countOnes(ch.therm) - `ARP_THERM_MID; // see R6
    x = '0;
    y = '0;
    push = 1'b0;
    acc = '0;
    w = '0;
    mag = '0;
    prod = '0;
    lvl = '0;
    s_d = s_q;
    s_d.wordVld = 1'b0;
    if (ch.modStb) begin
      s_d.integ[0] = s_q.integ[0] + {{(`ARP_SINC_W-6){dIn[5]}}, dIn}; // see R2
      for (int i = 1; i < 5; i++) begin
        s_d.integ[i] = s_q.integ[i] + s_q.integ[i-1];
      end
      s_d.sincCnt = s_q.sincCnt + 4'h1;
      if (s_q.sincCnt == (ch.sincShort ? `ARP_SINC_LAST_SHORT : `ARP_SINC_LAST_LONG)) begin // see R3
        s_d.sincCnt = '0;
        x = s_q.integ[4];
        for (int i = 0; i < 5; i++) begin
          y = x - s_q.combDly[i];
          s_d.combDly[i] = x;
          x = y;
        end
        if (ch.sincShort) begin
          x = x << `ARP_SHORT_SHIFT;
        end
        push = 1'b1;
      end
    end
    // Each half-band keeps seven taps and emits on every second input (see R2, R3).
    for (int st = 0; st < `ARP_HB_STAGES; st++) begin
      if (push) begin
        s_d.hbTap[st] = {s_q.hbTap[st][5:0], x};
        s_d.hbPh[st] = ~s_q.hbPh[st];
        push = s_q.hbPh[st];
        acc = (ext(s_d.hbTap[st][3]) <<< 4) + ((ext(s_d.hbTap[st][2]) + ext(s_d.hbTap[st][4])) <<< 3)
          + ext(s_d.hbTap[st][2]) + ext(s_d.hbTap[st][4]) - ext(s_d.hbTap[st][0])
          - ext(s_d.hbTap[st][6]);
        acc = acc >>> `ARP_HB_SHIFT;
        x = acc[`ARP_SINC_W-1:0];
      end
    end
    if (push) begin
      w = x[`ARP_SINC_W-1:`ARP_SINC_W-`ARP_WORD_W]; // see R4
      prod = $signed(w) * $signed({1'b0, `ARP_VOL_FULL - {1'b0, ch.volume}}); // see R8
      s_d.word = prod[`ARP_VOL_MSB:`ARP_VOL_LSB];
      s_d.wordVld = 1'b1;
      mag = w[`ARP_WORD_W-1] ? (~w + 24'h00_0001) : w;
      lvl = mag[`ARP_LEVEL_MSB:`ARP_LEVEL_LSB];
      s_d.level = lvl;
    end
    // A read clears the peak, but a sample landing in the same cycle still counts (see R9).
    if (ch.peakClr) begin
      s_d.peak = push ? lvl : 8'h00;
    end else if (push && (lvl > s_q.peak)) begin
      s_d.peak = lvl; // see R9
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.word = s_q.word;
  assign ch.wordVld = s_q.wordVld;
  assign ch.level = s_q.level;
  assign ch.peak = s_q.peak;
endmodule : arp_chan

/* File: hdl/arp_record_path.sv */
/*
  Record path of the stereo converter: clock division, two decimation channels, sample
  routing, level control of the input gain amplifier and the serial control port.
  Assumes core_clk is the selected converter master clock and the control port clock is
  much slower than core_clk, since its pins are sampled through two flip-flops.
*/
// Function
// R1: Modulator runs at half or quarter of converter clock, 128 or 64 sample rate.
// R2: Decimation is a fifth-order sinc followed by three half-band stages.
// R3: Sinc decimates by 16 or by 8; every half-band halves the rate.
// R4: Each sample leaves as a two's complement word of 24 bits.
// R5: Samples route to serial ports, rate converter or S/PDIF transmitter.
// R6: Thermometer code from the flash quantizer becomes a 5-bit binary word.
// R7: Amplifier gain is programmable from 0 to 24 dB in 0.5 dB steps.
// R8: Left and right volume each have 256 linear steps of 1/256.
// R9: Per-channel peak register holds the largest level and clears when read.
// R10: Master clock is divided by 1, 2 or 3 for 256, 512, 768 fs.
// R11: Software should give the output port clock the same divide value.
// R12: Modulator defaults to divide by two; a bit selects divide by four.
// R13: Output above attack threshold starts attack and lowers both gains one step.
// R14: In attack, wait attack time, resample, step down again until below threshold.
// R15: One common offset on both initial gains; gains never exceed initial values.
// R16: Detection setting one needs both channels over threshold; zero needs either.
// R17: No recovery by default until enable toggles or third control register is written.
// R18: Normal recovery raises gain one step per interval while output stays low.
// R19: Output over recovery threshold holds gain until it drops again.
// R20: Fully restored gain stays unchanged until the attack threshold is exceeded.
// R21: Limited recovery counts excursion intervals and stops recovery at the maximum.
// R22: In limited recovery an attack restarts attack mode and zeroes the counter.
// R23: Common offset saturates so no gain drops below the amplifier minimum.
`timescale 1ns/1ps
`include "arp_defs.svh"
module arp_record_path (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ctrlClk,
  input wire logic ctrlDataIn,
  input wire logic ctrlSelN,
  output logic ctrlDataOut,
  input wire logic [`ARP_THERM_W-1:0] thermLeft,
  input wire logic [`ARP_THERM_W-1:0] thermRight,
  output logic modClk,
  output logic [`ARP_GAIN_W-1:0] gainLeft,
  output logic [`ARP_GAIN_W-1:0] gainRight,
  output logic [`ARP_WORD_W-1:0] sampleLeft,
  output logic [`ARP_WORD_W-1:0] sampleRight,
  output logic portValid,
  output logic srcValid,
  output logic spdifValid
);
  arp_pkg::arp_top_state_t s_q;
  arp_pkg::arp_top_state_t s_d;

  arp_chan_if chL ();
  arp_chan_if chR ();

  arp_chan uChanL (
    .core_clk(core_clk),
    .resetn(resetn),
    .ch(chL.chan)
  );

  arp_chan uChanR (
    .core_clk(core_clk),
    .resetn(resetn),
    .ch(chR.chan)
  );

  assign chL.therm = s_q.thermL2;
  assign chR.therm = s_q.thermR2;
  assign chL.modStb = s_q.modStb;
  assign chR.modStb = s_q.modStb;
  assign chL.sincShort = s_q.adcCtrl[`ARP_ADC_QUARTER_BIT];
  assign chR.sincShort = s_q.adcCtrl[`ARP_ADC_QUARTER_BIT];
  assign chL.volume = s_q.volL;
  assign chR.volume = s_q.volR;
  assign chL.peakClr = s_q.peakClrL;
  assign chR.peakClr = s_q.peakClrR;

  function automatic logic [7:0] clampGain(input logic [7:0] v);
    return (v > {2'b00, `ARP_GAIN_MAX}) ? {2'b00, `ARP_GAIN_MAX} : v;
  endfunction : clampGain

  ////////////////////////////////////////////////////////////////////////////////
  // Register read multiplexer for the control port.
  function automatic logic [7:0] readReg(input arp_pkg::arp_top_state_t s, input logic [6:0] a,
    input logic [7:0] pkL, input logic [7:0] pkR);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `ARP_ADDR_ADC_CTRL: r = s.adcCtrl;
      `ARP_ADDR_GAIN_L: r = s.gainInitL;
      `ARP_ADDR_GAIN_R: r = s.gainInitR;
      `ARP_ADDR_VOL_L: r = s.volL;
      `ARP_ADDR_VOL_R: r = s.volR;
      `ARP_ADDR_PEAK_L: r = pkL;
      `ARP_ADDR_PEAK_R: r = pkR;
      `ARP_ADDR_CLK_CTRL: r = s.clkCtrl;
      `ARP_ADDR_ALC1: r = s.alc1;
      `ARP_ADDR_ALC2: r = s.alc2;
      `ARP_ADDR_ALC3: r = s.alc3;
      `ARP_ADDR_ALC4: r = s.alc4;
      `ARP_ADDR_ALC_STAT: r = {s.excCnt, 2'b00, s.alcState};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : readReg

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic sclkNow;
    logic clkRise;
    logic clkFall;
    logic selN;
    logic [15:0] frame;
    logic [1:0] divLast;
    logic adcStb;
    logic modNext;
    logic [`ARP_GAIN_W-1:0] offMax;
    logic [`ARP_GAIN_W-1:0] offStep;
    logic level_control_enable;
    logic vld;
    logic overAtkL;
    logic overAtkR;
    logic overAtk;
    logic overRec;
    logic seen;
    logic [11:0] atkLen;
    logic [11:0] recLen;
    logic [3:0] excMax;
    arp_pkg::arp_rec_mode_t mode;
    s_d = s_q;
    // Pins reach logic only after two flip-flops.
    s_d.pinSync1 = {ctrlSelN, ctrlDataIn, ctrlClk};
    s_d.pinSync2 = s_q.pinSync1;
    s_d.thermL1 = thermLeft;
    s_d.thermL2 = s_q.thermL1;
    s_d.thermR1 = thermRight;
    s_d.thermR2 = s_q.thermR1;
    sclkNow = s_q.pinSync2[0];
    selN = s_q.pinSync2[2];
    clkRise = sclkNow & ~s_q.clkPrev;
    clkFall = ~sclkNow & s_q.clkPrev;
    s_d.clkPrev = sclkNow;
    s_d.peakClrL = 1'b0;
    s_d.peakClrR = 1'b0;
    s_d.alcRst = 1'b0;
    frame = {s_q.shiftIn[14:0], s_q.pinSync2[1]};

    // Serial control port: 16-bit frame, read flag, 7-bit address, 8 data bits.
    if (selN) begin
      s_d.bitCnt = '0;
      s_d.dataOut = 1'b0;
    end else if (clkRise && (s_q.bitCnt != `ARP_SPI_FRAME_BITS)) begin
      s_d.shiftIn = frame;
      s_d.bitCnt = s_q.bitCnt + 5'h01;
      if ((s_d.bitCnt == `ARP_SPI_HEAD_BITS) && frame[7]) begin
        s_d.shiftOut = readReg(s_q, frame[6:0], chL.peak, chR.peak);
        s_d.peakClrL = (frame[6:0] == `ARP_ADDR_PEAK_L); // see R9
        s_d.peakClrR = (frame[6:0] == `ARP_ADDR_PEAK_R); // see R9
      end
      if ((s_d.bitCnt == `ARP_SPI_FRAME_BITS) && !frame[15]) begin
        unique case (frame[14:8])
          `ARP_ADDR_ADC_CTRL: s_d.adcCtrl = frame[7:0];
          `ARP_ADDR_GAIN_L: s_d.gainInitL = clampGain(frame[7:0]); // see R7
          `ARP_ADDR_GAIN_R: s_d.gainInitR = clampGain(frame[7:0]); // see R7
          `ARP_ADDR_VOL_L: s_d.volL = frame[7:0];
          `ARP_ADDR_VOL_R: s_d.volR = frame[7:0];
          `ARP_ADDR_CLK_CTRL: s_d.clkCtrl = frame[7:0];
          `ARP_ADDR_ALC1: s_d.alc1 = frame[7:0];
          `ARP_ADDR_ALC2: s_d.alc2 = frame[7:0];
          `ARP_ADDR_ALC3: begin
            s_d.alc3 = frame[7:0];
            s_d.alcRst = 1'b1; // see R17
          end
          `ARP_ADDR_ALC4: s_d.alc4 = frame[7:0];
          default: s_d.alc4 = s_q.alc4;
        endcase
      end
    end else if (clkFall && (s_q.bitCnt >= `ARP_SPI_HEAD_BITS)) begin
      s_d.dataOut = s_q.shiftOut[7];
      s_d.shiftOut = {s_q.shiftOut[6:0], 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Master clock divider and modulator clock.
    divLast = (s_q.clkCtrl[1:0] == 2'b00) ? 2'b00 : (s_q.clkCtrl[1:0] - 2'b01);
    adcStb = (s_q.mclkCnt == divLast); // see R10
    s_d.mclkCnt = adcStb ? 2'b00 : (s_q.mclkCnt + 2'b01);
    s_d.modStb = 1'b0;
    if (adcStb) begin
      s_d.modCnt = s_q.modCnt + 2'b01;
      modNext = s_q.adcCtrl[`ARP_ADC_QUARTER_BIT] ? s_d.modCnt[1] : s_d.modCnt[0]; // see R1, R12
      s_d.modClk = modNext;
      s_d.modStb = modNext & ~s_q.modClk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample routing.
    vld = chL.wordVld;
    s_d.portVld = vld & s_q.adcCtrl[`ARP_ROUTE_PORT_BIT]; // see R5
    s_d.srcVld = vld & s_q.adcCtrl[`ARP_ROUTE_SRC_BIT]; // see R5
    s_d.spdifVld = vld & s_q.adcCtrl[`ARP_ROUTE_SPDIF_BIT]; // see R5
    if (vld) begin
      s_d.sampleL = chL.word; // see R4
      s_d.sampleR = chR.word;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Automatic level control, stepping once per output sample.
    level_control_enable = s_q.alc1[`ARP_ALC_EN_BIT];
    s_d.alcEnPrev = level_control_enable;
    mode = arp_pkg::arp_rec_mode_t'(s_q.alc1[`ARP_ALC_MODE_MSB:`ARP_ALC_MODE_LSB]);
    excMax = s_q.alc1[`ARP_EXC_MAX_MSB:`ARP_EXC_MAX_LSB];
    atkLen = {4'h0, s_q.alc3[`ARP_ATK_TIME_MSB:0], `ARP_ATK_FILL};
    recLen = {s_q.alc3[7:`ARP_REC_TIME_LSB], `ARP_REC_FILL};
    overAtkL = chL.level > s_q.alc2;
    overAtkR = chR.level > s_q.alc2;
    overAtk = s_q.alc1[`ARP_ALC_BOTH_BIT] ? (overAtkL & overAtkR) : (overAtkL | overAtkR); // see R16
    overRec = (chL.level > s_q.alc4) | (chR.level > s_q.alc4);
    seen = s_q.recSeen | overRec;
    offMax = (s_q.gainInitL < s_q.gainInitR) ? s_q.gainInitL[`ARP_GAIN_W-1:0] :
      s_q.gainInitR[`ARP_GAIN_W-1:0];
    offStep = (s_q.gainOff < offMax) ? (s_q.gainOff + 6'h01) : offMax; // see R23
    if (!level_control_enable || (level_control_enable != s_q.alcEnPrev) || s_q.alcRst) begin
      s_d.alcState = level_control_enable ? arp_pkg::ARP_ALC_WATCH : arp_pkg::ARP_ALC_OFF; // see R17
      s_d.gainOff = '0;
      s_d.alcTimer = recLen;
      s_d.excCnt = '0;
      s_d.recSeen = 1'b0;
    end else if (vld) begin
      unique case (s_q.alcState)
        arp_pkg::ARP_ALC_OFF: begin
          s_d.alcState = arp_pkg::ARP_ALC_WATCH;
        end
        arp_pkg::ARP_ALC_WATCH: begin
          if (overAtk) begin
            s_d.alcState = arp_pkg::ARP_ALC_ATTACK; // see R13
            s_d.gainOff = offStep; // see R13
            s_d.alcTimer = atkLen;
            s_d.excCnt = '0; // see R22
            s_d.recSeen = 1'b0;
          end else if (s_q.alcTimer != 12'h000) begin
            s_d.alcTimer = s_q.alcTimer - 12'h001;
            s_d.recSeen = seen; // see R19
          end else begin
            s_d.alcTimer = recLen;
            s_d.recSeen = 1'b0;
            if ((mode == arp_pkg::ARP_REC_NORMAL) && !seen && (s_q.gainOff != '0)) begin
              s_d.gainOff = s_q.gainOff - 6'h01; // see R18, R20
            end
            if (mode == arp_pkg::ARP_REC_LIMITED) begin
              if (seen && (s_q.excCnt != excMax)) begin
                s_d.excCnt = s_q.excCnt + 4'h1; // see R21
              end else if (!seen && (s_q.excCnt != excMax) && (s_q.gainOff != '0)) begin
                s_d.gainOff = s_q.gainOff - 6'h01; // see R21
              end
            end
          end
        end
        arp_pkg::ARP_ALC_ATTACK: begin
          if (s_q.alcTimer != 12'h000) begin
            s_d.alcTimer = s_q.alcTimer - 12'h001; // see R14
          end else if (overAtk) begin
            s_d.gainOff = offStep; // see R14
            s_d.alcTimer = atkLen;
          end else begin
            s_d.alcState = arp_pkg::ARP_ALC_WATCH;
            s_d.alcTimer = recLen;
          end
        end
        default: s_d.alcState = arp_pkg::ARP_ALC_OFF;
      endcase
    end
    // Both gains take the same offset, so their difference is kept (see R15).
    s_d.gainL = (s_q.gainOff > s_q.gainInitL[`ARP_GAIN_W-1:0]) ? '0 :
      (s_q.gainInitL[`ARP_GAIN_W-1:0] - s_q.gainOff);
    s_d.gainR = (s_q.gainOff > s_q.gainInitR[`ARP_GAIN_W-1:0]) ? '0 :
      (s_q.gainInitR[`ARP_GAIN_W-1:0] - s_q.gainOff);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ctrlDataOut = s_q.dataOut;
  assign modClk = s_q.modClk;
  assign gainLeft = s_q.gainL;
  assign gainRight = s_q.gainR;
  assign sampleLeft = s_q.sampleL;
  assign sampleRight = s_q.sampleR;
  assign portValid = s_q.portVld;
  assign srcValid = s_q.srcVld;
  assign spdifValid = s_q.spdifVld;
endmodule : arp_record_path

/* File: sim/arp_record_path_sva.sv */
/* Checker of the record path top ports: strobes, sample spacing, gains, modulator clock.
   Assumes it is bound to the top and sees only its ports. */
`timescale 1ns/1ps
`include "arp_defs.svh"
module arp_record_path_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic modClk,
  input wire logic [`ARP_GAIN_W-1:0] gainLeft,
  input wire logic [`ARP_GAIN_W-1:0] gainRight,
  input wire logic [`ARP_WORD_W-1:0] sampleLeft,
  input wire logic [`ARP_WORD_W-1:0] sampleRight,
  input wire logic portValid,
  input wire logic srcValid,
  input wire logic spdifValid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic anyValid;
  logic [8:0] gap_q;
  logic [3:0] run_q;
  assign anyValid = portValid | srcValid | spdifValid;
  // Cycles since the last strobe and since the last modulator clock change, saturating.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap_q <= 9'h1FF;
      run_q <= 4'h0;
    end else begin
      gap_q <= anyValid ? 9'h000 : gap_q + 9'(gap_q != 9'h1FF);
      run_q <= $changed(modClk) ? 4'h0 : run_q + 4'(run_q != 4'hF);
    end
  end
  sequence heldAfter;
    ($stable(sampleLeft) && $stable(sampleRight)) [*8];
  endsequence
  property pulseOnce(v);
    v |=> !v;
  endproperty
  a_port_pulse: assert property (pulseOnce(portValid))
    else $error("port strobe too long");
  a_src_pulse: assert property (pulseOnce(srcValid))
    else $error("converter strobe too long");
  a_spdif_pulse: assert property (pulseOnce(spdifValid))
    else $error("transmitter strobe too long");
  a_sample_hold: assert property (anyValid |=> heldAfter)
    else $error("sample changed between strobes");
  a_sample_gap: assert property (anyValid |-> gap_q >= 9'h0FF)
    else $error("samples closer than one sample period");
  a_gain_cap_l: assert property (gainLeft <= `ARP_GAIN_MAX)
    else $error("left gain above range");
  a_gain_cap_r: assert property (gainRight <= `ARP_GAIN_MAX)
    else $error("right gain above range");
  a_common_step: assert property (($changed(gainLeft) && $changed(gainRight)) |->
    (gainLeft - $past(gainLeft)) == (gainRight - $past(gainRight)))
    else $error("gains moved by different offsets");
  a_modclk_run: assert property (run_q < 4'hC)
    else $error("modulator clock stalled");
endmodule : arp_record_path_sva

bind arp_record_path arp_record_path_sva u_sva (.core_clk(core_clk), .resetn(resetn),
  .modClk(modClk), .gainLeft(gainLeft), .gainRight(gainRight), .sampleLeft(sampleLeft),
  .sampleRight(sampleRight), .portValid(portValid), .srcValid(srcValid),
  .spdifValid(spdifValid));

/* File: sim/arp_front_model.sv */
/* Behavioural front end: a slow square wave whose size follows the amplifier gain.
   Assumes the quantizer code changes on rising modulator clock edges. */
`timescale 1ns/1ps
`include "arp_defs.svh"
module arp_front_model (
  input wire logic modClk,
  input wire logic [`ARP_GAIN_W-1:0] gainLeft,
  input wire logic [`ARP_GAIN_W-1:0] gainRight,
  input wire logic [3:0] ampL,
  input wire logic [3:0] ampR,
  output logic [`ARP_THERM_W-1:0] thermLeft,
  output logic [`ARP_THERM_W-1:0] thermRight
);
  logic [9:0] phase = 10'h000;
  // Sixteen ones is mid scale; the swing grows with the gain code.
  function automatic logic [`ARP_THERM_W-1:0] code(input logic [3:0] amp,
    input logic [5:0] gain, input logic neg);
    logic [9:0] k;
    k = (10'(amp) * (10'(gain) + 10'h010)) >> 6;
    return neg ? (31'h7FFF_FFFF >> (15 + k)) : (31'h7FFF_FFFF >> (15 - k));
  endfunction : code
  initial begin
    thermLeft = 31'h0000_FFFF;
    thermRight = 31'h0000_FFFF;
  end
  always @(posedge modClk) begin
    phase <= phase + 10'h001;
    thermLeft <= code(ampL, gainLeft, phase[9]);
    thermRight <= code(ampR, gainRight, phase[9]);
  end
endmodule : arp_front_model

/* File: sim/tb_arp_record_path.sv */
/* Self-checking bench of the record path.
   Assumes the front-end model and the checker are compiled alongside. */
`timescale 1ns/1ps
`include "arp_defs.svh"
module tb_arp_record_path;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic ctrlClk = 1'b0;
  logic ctrlDataIn = 1'b0;
  logic ctrlSelN = 1'b1;
  logic ctrlDataOut, modClk, portValid, srcValid, spdifValid;
  logic [`ARP_THERM_W-1:0] thermLeft, thermRight;
  logic [`ARP_GAIN_W-1:0] gainLeft, gainRight;
  logic [`ARP_WORD_W-1:0] sampleLeft, sampleRight;
  logic [3:0] ampL = 4'h0;
  logic [3:0] ampR = 4'h0;
  logic [7:0] rdByte, rnd;
  logic [7:0] expQ[$];
  int err_total = 0;
  int n_tests = 0;
  int seed = 45;
  int nPort = 0;
  int nSrc = 0;
  int nSpdif = 0;
  int p0, s0, f0;
  event rdDone;
  always #50 core_clk = ~core_clk;
  arp_record_path u_dut (.core_clk(core_clk), .resetn(resetn), .ctrlClk(ctrlClk),
    .ctrlDataIn(ctrlDataIn), .ctrlSelN(ctrlSelN), .ctrlDataOut(ctrlDataOut),
    .thermLeft(thermLeft), .thermRight(thermRight), .modClk(modClk), .gainLeft(gainLeft),
    .gainRight(gainRight), .sampleLeft(sampleLeft), .sampleRight(sampleRight),
    .portValid(portValid), .srcValid(srcValid), .spdifValid(spdifValid));
  arp_front_model u_front (.modClk(modClk), .gainLeft(gainLeft), .gainRight(gainRight),
    .ampL(ampL), .ampR(ampR), .thermLeft(thermLeft), .thermRight(thermRight));
  always @(posedge core_clk) begin
    nPort <= nPort + int'(portValid);
    nSrc <= nSrc + int'(srcValid);
    nSpdif <= nSpdif + int'(spdifValid);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_clk
  // Each control clock phase lasts eight cycles for the synchronisers.
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] data);
    ctrlSelN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ctrlClk <= 1'b0;
      ctrlDataIn <= (i == 15) ? rd : ((i > 7) ? addr[i-8] : data[i]);
      wait_clk(7);
      @(negedge core_clk);
      if (i < 8) rdByte[i] = ctrlDataOut;
      @(posedge core_clk);
      ctrlClk <= 1'b1;
      wait_clk(8);
    end
    ctrlClk <= 1'b0;
    wait_clk(8);
    ctrlSelN <= 1'b1;
    wait_clk(8);
  endtask : frame
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    frame(1'b0, addr, data);
  endtask : wr
  task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
    expQ.push_back(exp);
    frame(1'b1, addr, 8'h00);
    ->rdDone;
  endtask : rd
  task automatic gains(input logic [5:0] l, input logic [5:0] r);
    check({18'h0_0000, gainLeft}, {18'h0_0000, l});
    check({18'h0_0000, gainRight}, {18'h0_0000, r});
  endtask : gains
  task automatic close_out;
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial forever begin
    @(rdDone);
    check({16'h0000, rdByte}, {16'h0000, expQ.pop_front()});
  end
  initial begin
    wait_clk(90000);
    err_total++;
    close_out();
  end
  initial begin
    wait_clk(6);
    resetn <= 1'b1;
    wait_clk(4);
    rd(`ARP_ADDR_CLK_CTRL, 8'h00);
    rnd = 8'($random(seed));
    wr(`ARP_ADDR_CLK_CTRL, {rnd[7:2], 2'b01});
    rd(`ARP_ADDR_CLK_CTRL, {rnd[7:2], 2'b01});
    wr(7'h77, rnd);
    rd(7'h77, 8'h00);
    $display("register test done");
    ampL <= 4'($random(seed)) | 4'h8;
    ampR <= 4'($random(seed)) | 4'h8;
    wait_clk(3000);
    for (int k = 1; k <= 3; k++) begin
      wr(`ARP_ADDR_ADC_CTRL, 8'((1 << k) | int'(k == 3)));
      p0 = nPort;
      s0 = nSrc;
      f0 = nSpdif;
      wait_clk(1500);
      check(24'(nPort > p0), 24'(k == 1));
      check(24'(nSrc > s0), 24'(k == 2));
      check(24'(nSpdif > f0), 24'(k == 3));
    end
    $display("routing test done");
    ampL <= 4'h0;
    ampR <= 4'h0;
    wait_clk(12000);
    frame(1'b1, `ARP_ADDR_PEAK_L, 8'h00);
    frame(1'b1, `ARP_ADDR_PEAK_R, 8'h00);
    rd(`ARP_ADDR_PEAK_L, 8'h00);
    rd(`ARP_ADDR_PEAK_R, 8'h00);
    $display("peak test done");
    wr(`ARP_ADDR_GAIN_L, 8'h3F);
    wr(`ARP_ADDR_GAIN_R, 8'h04);
    rd(`ARP_ADDR_GAIN_L, 8'h30);
    gains(6'h30, 6'h04);
    wr(`ARP_ADDR_ALC2, 8'h08);
    wr(`ARP_ADDR_ALC3, 8'h00);
    wr(`ARP_ADDR_ALC1, 8'h03);
    ampL <= 4'hF;
    wait_clk(6000);
    gains(6'h30, 6'h04);
    wr(`ARP_ADDR_ALC1, 8'h01);
    wait_clk(24000);
    gains(6'h2C, 6'h00);
    ampL <= 4'h0;
    wait_clk(6000);
    gains(6'h2C, 6'h00);
    wr(`ARP_ADDR_ALC3, 8'h00);
    wait_clk(20);
    gains(6'h30, 6'h04);
    $display("level control test done");
    close_out();
  end
endmodule : tb_arp_record_path
